// [src/npc_codec.sv]
// Payload decoder for the eight aiding and rate packets, encoder for ids 42, 43 and 49
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// (R1) Id 42: 12 bytes, X/Y/Z angular rate floats at 0, 4, 8.
// (R2) Id 43: 12 bytes, X/Y/Z angular acceleration floats at 0, 4, 8.
// (R3) Id 44: 60 bytes, lat/lon/height doubles at 0, 8, 16.
// (R4) Id 44: N/E/D velocity floats at 24, 28, 32.
// (R5) Id 44: position deviation floats at 36, 40, 44.
// (R6) Id 44: velocity deviation floats at 48, 52, 56.
// (R7) Id 45: 36 bytes, doubles at 0/8/16, deviations at 24/28/32.
// (R8) Id 46: 24 bytes, velocities at 0/4/8, deviations at 12/16/20.
// (R9) Id 47: 16 or 24 bytes, velocities 0/4/8, X deviation at 12.
// (R10) Receiver takes both 47 lengths; short form shares one deviation.
// (R11) Sender of 47 sets header length to match chosen format.
// (R12) Id 48: 8 bytes, heading float at 0, deviation at 4.
// (R13) Id 49: 8 bytes, u32 seconds at 0, u32 microseconds at 4.
// (R14) Multi-byte fields go LSB first; floats are IEEE single/double.
// (R15) Long 47 form: Y and Z deviations at 16 and 20.
// (R16) Packets with wrong length for their id are dropped unstored.
module npc_codec #(
   parameter int DEPTH = npc_pkg::FIFO_DEPTH
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // Received payload, framed: id and length with the first byte
   input wire logic i_rx_valid,
   output logic o_rx_ready,
   input wire logic [7:0] i_rx_data,
   input wire logic i_rx_first,
   input wire logic [7:0] i_rx_id,
   input wire logic [7:0] i_rx_len,
   // Decoded packet result
   output logic o_pkt_done,
   output logic o_pkt_drop,
   output logic [7:0] o_pkt_id,
   output logic [7:0] o_pkt_len,
   // Random read of stored fields by packet id and word slot
   input wire logic [7:0] i_rd_id,
   input wire logic [3:0] i_rd_slot,
   output logic [31:0] o_rd_word,
   // Encoder: pick id 42, 43 or 49 to send from stored words
   input wire logic i_tx_start,
   input wire logic [7:0] i_tx_id,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   output logic [7:0] o_tx_data,
   output logic o_tx_last,
   output logic o_tx_busy
);
   localparam int NPKT = 8;
   typedef struct packed {
      npc_pkg::npc_state_e state;
      logic [7:0] id;
      logic [7:0] len;
      logic [7:0] cnt;
      logic [31:0] shift;
      logic [NPKT*npc_pkg::SLOTS*32-1:0] store;
      logic [NPKT*npc_pkg::SLOTS*32-1:0] stage;
      logic done;
      logic drop;
      logic [31:0] rd_word;
      logic tx_busy;
      logic [2:0] tx_pkt;
      logic [7:0] tx_cnt;
      logic [7:0] tx_len;
      logic tx_valid;
      logic [7:0] tx_data;
      logic tx_last;
   } npc_codec_s;
   npc_codec_s st;
   npc_codec_s next_st;

   logic f_valid;
   logic f_ready;
   logic [7:0] f_data;
   logic f_first;
   logic [7:0] f_id;
   logic [7:0] f_len;

   // Payload bytes buffered so the decoder may stall the source
   npc_fifo #(
      .WIDTH(npc_pkg::FIFO_WIDTH + 17),
      .DEPTH(DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_in_valid(i_rx_valid),
      .o_in_ready(o_rx_ready),
      .i_in_data({i_rx_first, i_rx_id, i_rx_len, i_rx_data}),
      .o_out_valid(f_valid),
      .i_out_ready(f_ready),
      .o_out_data({f_first, f_id, f_len, f_data})
   );

   // Packet index 0..7 from identifier, 0 marks unknown via flag
   function automatic logic [3:0] pkt_index(input logic [7:0] id);
      logic [7:0] d;
      d = id - npc_pkg::ID_ANG_VEL;
      pkt_index = (id >= npc_pkg::ID_ANG_VEL && id <= npc_pkg::ID_RUN_TIME) ?
         {1'b1, d[2:0]} : 4'h0;
   endfunction : pkt_index

   // Permitted length check per identifier
   function automatic logic len_ok(input logic [7:0] id, input logic [7:0] len);
      len_ok = 1'b0;
      unique case (id)
         // (R1) Angular rate length
         npc_pkg::ID_ANG_VEL: len_ok = (len == npc_pkg::LEN_ANG);
         // (R2) Angular accel length
         npc_pkg::ID_ANG_ACC: len_ok = (len == npc_pkg::LEN_ANG);
         // (R3) Position-velocity length
         npc_pkg::ID_EXT_POSVEL: len_ok = (len == npc_pkg::LEN_POSVEL);
         // (R7) Position length
         npc_pkg::ID_EXT_POS: len_ok = (len == npc_pkg::LEN_POS);
         // (R8) Velocity length
         npc_pkg::ID_EXT_VEL: len_ok = (len == npc_pkg::LEN_VEL);
         // (R10) Both body lengths
         npc_pkg::ID_EXT_BODYVEL: len_ok = (len == npc_pkg::LEN_BODY_SHORT) ||
            (len == npc_pkg::LEN_BODY_LONG);
         // (R12) Heading length
         npc_pkg::ID_EXT_HEAD: len_ok = (len == npc_pkg::LEN_HEAD);
         // (R13) Running time length
         npc_pkg::ID_RUN_TIME: len_ok = (len == npc_pkg::LEN_TIME);
         default: len_ok = 1'b0;
      endcase
   endfunction : len_ok

   // Main decode and encode process
   always_comb begin
      logic [3:0] pi;
      logic [3:0] ti;
      logic [9:0] base;
      logic [9:0] tbase;
      logic [31:0] word;
      ti = 4'h0;
      tbase = 10'h000;
      next_st = st;
      next_st.done = 1'b0;
      next_st.drop = 1'b0;
      f_ready = 1'b0;
      pi = pkt_index(st.id);
      base = 10'({pi[2:0], 4'h0}) - 10'(pi[2:0]);
      word = {f_data, st.shift[31:8]};
      unique case (st.state)
         npc_pkg::ST_IDLE: begin
            f_ready = 1'b1;
            // Bytes not marked first outside a packet are discarded
            if (f_valid && f_first) begin
               next_st.id = f_id;
               next_st.len = f_len;
               next_st.cnt = 8'h01;
               next_st.shift = {f_data, st.shift[31:8]};
               next_st.stage = st.store;
               next_st.state = (f_len == 8'h01) ? npc_pkg::ST_DONE : npc_pkg::ST_BODY;
            end
         end
         npc_pkg::ST_BODY: begin
            f_ready = 1'b1;
            if (f_valid) begin
               // (R14) Bytes shift in LSB first
               next_st.shift = word;
               next_st.cnt = st.cnt + 8'h01;
               // (R4) Each full word lands in its offset slot
               // (R5) Position deviations at slots 9-11
               // (R6) Velocity deviations at slots 12-14
               // (R9) Body velocities and X deviation
               // (R15) Long form Y/Z at slots 4-5
               if (st.cnt[1:0] == 2'b11 && pi[3]) begin
                  next_st.stage[(10'(base) + 10'(st.cnt[7:2])) * 32 +: 32] = word;
               end
               if (st.cnt + 8'h01 == st.len) begin
                  next_st.state = npc_pkg::ST_DONE;
               end
            end
         end
         npc_pkg::ST_DONE: begin
            next_st.state = npc_pkg::ST_IDLE;
            // (R16) Commit only a well formed packet
            if (len_ok(st.id, st.len)) begin
               next_st.store = st.stage;
               // (R10) Short form copies X deviation to Y and Z
               if (st.id == npc_pkg::ID_EXT_BODYVEL && st.len == npc_pkg::LEN_BODY_SHORT) begin
                  next_st.store[(base + 10'(npc_pkg::SLOT_SD_Y)) * 32 +: 32] =
                     st.stage[(base + 10'(npc_pkg::SLOT_SD_X)) * 32 +: 32];
                  next_st.store[(base + 10'(npc_pkg::SLOT_SD_Z)) * 32 +: 32] =
                     st.stage[(base + 10'(npc_pkg::SLOT_SD_X)) * 32 +: 32];
               end
               next_st.done = 1'b1;
            end else begin
               next_st.drop = 1'b1;
            end
         end
         default: next_st.state = npc_pkg::ST_IDLE;
      endcase

      // Field readback; unknown id reads zero
      ti = pkt_index(i_rd_id);
      tbase = 10'({ti[2:0], 4'h0}) - 10'(ti[2:0]);
      next_st.rd_word = (ti[3] && i_rd_slot < 4'(npc_pkg::SLOTS)) ?
         st.store[(tbase + 10'(i_rd_slot)) * 32 +: 32] : 32'h0000_0000;

      // Encoder: stream stored payload LSB first with handshake
      tbase = 10'({st.tx_pkt, 4'h0}) - 10'(st.tx_pkt);
      if (!st.tx_busy) begin
         if (i_tx_start && (i_tx_id == npc_pkg::ID_ANG_VEL ||
               i_tx_id == npc_pkg::ID_ANG_ACC || i_tx_id == npc_pkg::ID_RUN_TIME)) begin
            next_st.tx_busy = 1'b1;
            next_st.tx_pkt = 3'(i_tx_id - npc_pkg::ID_ANG_VEL);
            // (R13) Running time is 8 bytes, rates 12
            next_st.tx_len = (i_tx_id == npc_pkg::ID_RUN_TIME) ?
               npc_pkg::LEN_TIME : npc_pkg::LEN_ANG;
            next_st.tx_cnt = 8'h00;
            next_st.tx_valid = 1'b0;
         end
      end else if (!st.tx_valid || i_tx_ready) begin
         if (st.tx_valid && st.tx_last) begin
            next_st.tx_busy = 1'b0;
            next_st.tx_valid = 1'b0;
            next_st.tx_last = 1'b0;
         end else begin
            // (R14) Byte k of word taken from low end first
            next_st.tx_data = st.store[(tbase + 10'(st.tx_cnt[7:2])) * 32 +
               32'(st.tx_cnt[1:0]) * 8 +: 8];
            next_st.tx_valid = 1'b1;
            next_st.tx_last = (st.tx_cnt + 8'h01 == st.tx_len);
            next_st.tx_cnt = st.tx_cnt + 8'h01;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign o_pkt_done = st.done;
   assign o_pkt_drop = st.drop;
   assign o_pkt_id = st.id;
   assign o_pkt_len = st.len;
   assign o_rd_word = st.rd_word;
   assign o_tx_valid = st.tx_valid;
   assign o_tx_data = st.tx_data;
   assign o_tx_last = st.tx_last;
   assign o_tx_busy = st.tx_busy;
endmodule : npc_codec
`default_nettype wire

// [inc/npc_pkg.sv]
// Package: packet identifiers, lengths, field offsets and FIFO sizing for the payload codec
package npc_pkg;
   // Packet identifiers
   localparam logic [7:0] ID_ANG_VEL = 8'h2A;
   localparam logic [7:0] ID_ANG_ACC = 8'h2B;
   localparam logic [7:0] ID_EXT_POSVEL = 8'h2C;
   localparam logic [7:0] ID_EXT_POS = 8'h2D;
   localparam logic [7:0] ID_EXT_VEL = 8'h2E;
   localparam logic [7:0] ID_EXT_BODYVEL = 8'h2F;
   localparam logic [7:0] ID_EXT_HEAD = 8'h30;
   localparam logic [7:0] ID_RUN_TIME = 8'h31;
   // Payload lengths in bytes
   localparam logic [7:0] LEN_ANG = 8'h0C;
   localparam logic [7:0] LEN_POSVEL = 8'h3C;
   localparam logic [7:0] LEN_POS = 8'h24;
   localparam logic [7:0] LEN_VEL = 8'h18;
   localparam logic [7:0] LEN_BODY_SHORT = 8'h10;
   localparam logic [7:0] LEN_BODY_LONG = 8'h18;
   localparam logic [7:0] LEN_HEAD = 8'h08;
   localparam logic [7:0] LEN_TIME = 8'h08;
   // Word slots of 4 bytes; a 64-bit float takes two slots, low word first
   localparam int SLOTS = 15;
   localparam logic [7:0] BODY_SD_X_OFS = 8'h0C;
   localparam logic [7:0] BODY_SD_Y_OFS = 8'h10;
   localparam logic [7:0] BODY_SD_Z_OFS = 8'h14;
   // Store slot indices for the body velocity deviations
   localparam logic [3:0] SLOT_SD_X = 4'h3;
   localparam logic [3:0] SLOT_SD_Y = 4'h4;
   localparam logic [3:0] SLOT_SD_Z = 4'h5;
   // Data FIFO
   localparam int FIFO_WIDTH = 8;
   localparam int FIFO_DEPTH = 16;
   // Decoder states, Gray coded in listed order; the path used skips ST_LEN (IDLE to BODY flips two bits)
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_LEN = 2'b01,
      ST_BODY = 2'b11,
      ST_DONE = 2'b10
   } npc_state_e;
endpackage : npc_pkg

// [src/npc_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module npc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW:0] wr;
      logic [AW:0] rd;
   } npc_fifo_s;
   npc_fifo_s st;
   npc_fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic full;
   logic empty;
   logic push;
   logic pop;

   // Full when pointers differ only in the wrap bit
   assign full = (st.wr[AW] != st.rd[AW]) && (st.wr[AW-1:0] == st.rd[AW-1:0]);
   assign empty = (st.wr == st.rd);
   assign push = i_in_valid && !full;
   assign pop = i_out_ready && !empty;
   assign o_in_ready = !full;
   assign o_out_valid = !empty;
   assign o_out_data = mem[st.rd[AW-1:0]];

   // Pointer update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wr = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // Storage needs no reset; empty flag hides stale words
   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[st.wr[AW-1:0]] <= i_in_data;
      end
   end
endmodule : npc_fifo
`default_nettype wire

// [dv/npc_codec_asserts.sv]
// Port checker for the payload codec
`timescale 1ns/10ps
`default_nettype none
module npc_codec_chk (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_rd_slot,
   input wire logic [31:0] o_rd_word,
   input wire logic i_tx_start,
   input wire logic [7:0] i_tx_id,
   input wire logic i_tx_ready,
   input wire logic o_tx_valid,
   input wire logic [7:0] o_tx_data,
   input wire logic o_tx_last,
   input wire logic o_tx_busy,
   input wire logic o_pkt_done,
   input wire logic o_pkt_drop,
   input wire logic [7:0] o_pkt_id,
   input wire logic [7:0] o_pkt_len
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // Allowed length per id; both forms of 47 count
   function automatic logic legal(input logic [7:0] id, input logic [7:0] n);
      case (id)
         8'h2A, 8'h2B: legal = (n == 8'h0C);
         8'h2C: legal = (n == 8'h3C);
         8'h2D: legal = (n == 8'h24);
         8'h2E: legal = (n == 8'h18);
         8'h2F: legal = (n == 8'h10) || (n == 8'h18);
         8'h30, 8'h31: legal = (n == 8'h08);
         default: legal = 1'b0;
      endcase
   endfunction : legal
   a_done_len_legal: assert property (o_pkt_done |-> legal(o_pkt_id, o_pkt_len))
      else $error("done with an illegal length");
   a_drop_len_bad: assert property (o_pkt_drop |-> !legal(o_pkt_id, o_pkt_len))
      else $error("drop with a legal length");
   a_pulse_excl: assert property (!(o_pkt_done && o_pkt_drop))
      else $error("done and drop together");
   a_tx_start_lat: assert property ((i_tx_start && !o_tx_busy
      && i_tx_id inside {8'h2A, 8'h2B, 8'h31}) |=> o_tx_busy ##1 o_tx_valid)
      else $error("encoder start latency wrong");
   a_tx_ignore_id: assert property ((i_tx_start && !o_tx_busy
      && !(i_tx_id inside {8'h2A, 8'h2B, 8'h31})) |=> !o_tx_busy [*2])
      else $error("encoder took an unsupported id");
   a_tx_hold_stall: assert property (o_tx_valid && !i_tx_ready
      |=> o_tx_valid && $stable(o_tx_data) && $stable(o_tx_last))
      else $error("encoder byte changed while stalled");
   a_tx_end_idle: assert property (o_tx_valid && o_tx_last && i_tx_ready
      |-> ##[1:2] !o_tx_busy)
      else $error("busy stayed after last byte");
   a_rd_slot_range: assert property (i_rd_slot == 4'hF |=> o_rd_word == 32'h0)
      else $error("slot 15 read not zero");
   a_reset_clear: assert property ($fell(i_sys_rst) |-> !o_pkt_done && !o_pkt_drop
      && !o_tx_valid && !o_tx_busy && o_rd_word == 32'h0)
      else $error("outputs not clear after reset");
   c_short_body: cover property (o_pkt_done && o_pkt_id == 8'h2F && o_pkt_len == 8'h10);
   c_drop: cover property (o_pkt_drop);
   c_tx_stall: cover property (o_tx_valid && !i_tx_ready);
endmodule : npc_codec_chk
bind npc_codec npc_codec_chk npc_codec_chk_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
   .i_rd_slot(i_rd_slot), .o_rd_word(o_rd_word), .i_tx_start(i_tx_start),
   .i_tx_id(i_tx_id), .i_tx_ready(i_tx_ready), .o_tx_valid(o_tx_valid),
   .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .o_tx_busy(o_tx_busy),
   .o_pkt_done(o_pkt_done), .o_pkt_drop(o_pkt_drop), .o_pkt_id(o_pkt_id),
   .o_pkt_len(o_pkt_len));
`default_nettype wire

// [dv/npc_host_model.sv]
// Host side model: sends payload bytes and sinks encoded bytes
`timescale 1ns/10ps
`default_nettype none
module npc_host_model (
   input wire logic i_clk,
   output logic o_rx_valid,
   input wire logic i_rx_ready,
   output logic [7:0] o_rx_data,
   output logic o_rx_first,
   output logic [7:0] o_rx_id,
   output logic [7:0] o_rx_len,
   input wire logic i_tx_valid,
   output logic o_tx_ready,
   input wire logic [7:0] i_tx_data
);
   logic stall = 1'b0;
   logic [7:0] got[$];
   int cyc = 0;
   initial begin
      o_rx_valid = 1'b0;
      o_rx_first = 1'b0;
      o_rx_data = 8'h00;
      o_rx_id = 8'h00;
      o_rx_len = 8'h00;
      o_tx_ready = 1'b1;
   end
   task automatic send(input logic [7:0] id, input logic [7:0] len, input logic [7:0] sd);
      for (int k = 0; k < len; k++) begin
         @(negedge i_clk);
         o_rx_valid = 1'b1;
         o_rx_first = (k == 0);
         // Header fields are only meaningful with the first byte
         o_rx_id = (k == 0) ? id : ~id;
         o_rx_len = (k == 0) ? len : ~len;
         o_rx_data = sd + 8'(k);
         // Ready only moves on rising edges, so look at it settled here
         while (!i_rx_ready) @(negedge i_clk);
         @(posedge i_clk);
      end
      @(negedge i_clk);
      o_rx_valid = 1'b0;
      o_rx_first = 1'b0;
      o_rx_data = ~o_rx_data;
   endtask : send
   // Stall holds ready low two cycles in three; a byte counts when valid
   // and the new ready meet, since both stand through the next rising edge
   always @(negedge i_clk) begin
      cyc++;
      o_tx_ready = !stall || (cyc % 3 == 0);
      if (i_tx_valid && o_tx_ready) got.push_back(i_tx_data);
   end
endmodule : npc_host_model
`default_nettype wire

// [dv/nav_packet_payload_codec_test.sv]
// Self-checking bench for the payload codec
`timescale 1ns/10ps
`default_nettype none
module nav_packet_payload_codec_test;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tx_start = 1'b0;
   logic rx_valid, rx_ready, rx_first, pkt_done, pkt_drop, tx_valid, tx_ready, tx_last, tx_busy;
   logic [7:0] rx_data, rx_id, rx_len, pkt_id, pkt_len, tx_data;
   logic [7:0] rd_id = 8'h00;
   logic [7:0] tx_id = 8'h00;
   logic [3:0] rd_slot = 4'h0;
   logic [31:0] rd_word;
   logic [31:0] st[8][15];
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   // Rows: id, length, stored (bit per row); the last three are dropped
   logic [7:0] r_id[12] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h2F, 8'h30, 8'h31,
      8'h2A, 8'h2F, 8'h31};
   logic [7:0] r_len[12] = '{8'h0C, 8'h0C, 8'h3C, 8'h24, 8'h18, 8'h18, 8'h10, 8'h08, 8'h08,
      8'h10, 8'h14, 8'h0C};
   logic [11:0] r_ok = 12'h1FF;
   npc_codec npc_codec_i (.i_clk(clk), .i_sys_rst(rst), .i_rx_valid(rx_valid),
      .o_rx_ready(rx_ready), .i_rx_data(rx_data), .i_rx_first(rx_first), .i_rx_id(rx_id),
      .i_rx_len(rx_len), .o_pkt_done(pkt_done), .o_pkt_drop(pkt_drop), .o_pkt_id(pkt_id),
      .o_pkt_len(pkt_len), .i_rd_id(rd_id), .i_rd_slot(rd_slot), .o_rd_word(rd_word),
      .i_tx_start(tx_start), .i_tx_id(tx_id), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
      .o_tx_data(tx_data), .o_tx_last(tx_last), .o_tx_busy(tx_busy));
   npc_host_model host_i (.i_clk(clk), .o_rx_valid(rx_valid), .i_rx_ready(rx_ready),
      .o_rx_data(rx_data), .o_rx_first(rx_first), .o_rx_id(rx_id), .o_rx_len(rx_len),
      .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_tx_data(tx_data));
   always #2.5 clk = ~clk;
   // Hang guard, far above the several hundred cycles needed
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         tally_and_finish();
      end
   end
   // Word of slot s for a byte ramp starting at sd
   function automatic logic [31:0] wd(input logic [7:0] sd, input int s);
      wd = {sd + 8'(4 * s + 3), sd + 8'(4 * s + 2), sd + 8'(4 * s + 1), sd + 8'(4 * s)};
   endfunction : wd
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic rd_chk(input logic [7:0] id, input logic [3:0] s, input logic [31:0] e);
      @(negedge clk);
      rd_id = id;
      rd_slot = s;
      @(negedge clk);
      cmp(rd_word, e);
   endtask : rd_chk
   task automatic tx_run(input logic [7:0] id, input int nb);
      int n;
      n = 0;
      host_i.got.delete();
      @(negedge clk);
      tx_start = 1'b1;
      tx_id = id;
      @(negedge clk);
      tx_start = 1'b0;
      while ((tx_busy !== 1'b0 || host_i.got.size() < nb) && n < 300) begin
         @(negedge clk);
         n++;
      end
      cmp(host_i.got.size(), nb);
   endtask : tx_run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      logic [7:0] sd;
      int n;
      foreach (st[a, b]) st[a][b] = 32'h0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 12; i++) begin
         sd = 8'(i * 16 + 1);
         host_i.send(r_id[i], r_len[i], sd);
         n = 0;
         while (pkt_done !== 1'b1 && pkt_drop !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
         end
         cmp(pkt_done, r_ok[i]);
         cmp(pkt_drop, !r_ok[i]);
         cmp(pkt_len, r_len[i]);
         cmp(pkt_id, r_id[i]);
         for (int s = 0; r_ok[i] && s < r_len[i] / 4; s++)
            st[r_id[i] - 8'h2A][s] = wd(sd, s);
         if (r_ok[i] && r_len[i] == 8'h10) begin
            st[5][4] = st[5][3];
            st[5][5] = st[5][3];
         end
         for (int s = 0; s < 15; s++)
            rd_chk(r_id[i], 4'(s), st[r_id[i] - 8'h2A][s]);
      end
      rd_chk(8'h2F, 4'h5, wd(8'h61, 3));
      rd_chk(8'h32, 4'h0, 32'h0);
      rd_chk(8'h2A, 4'hF, 32'h0);
      host_i.stall = 1'b1;
      tx_run(8'h2A, 12);
      for (int b = 0; b < 12; b++)
         cmp(host_i.got[b], st[0][b / 4] >> (8 * (b % 4)) & 32'hFF);
      host_i.stall = 1'b0;
      tx_run(8'h31, 8);
      for (int b = 0; b < 8; b++)
         cmp(host_i.got[b], st[7][b / 4] >> (8 * (b % 4)) & 32'hFF);
      tx_run(8'h2C, 0);
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      cmp(tx_busy, 1'b0);
      rd_chk(8'h31, 4'h0, 32'h0);
      tally_and_finish();
   end
endmodule : nav_packet_payload_codec_test
`default_nettype wire
